// >>> faic_device.sv
// Device end: command decode, format sequencer and identification FIFO
`timescale 1ns/100ps
`default_nettype none
module faic_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  // Depth must be a power of two for the wrapping pointers
  if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
    $error("faic_fifo depth must be a power of two >= 2");
  end
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;
  // Pointer and fill count updates
  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
  // Storage, no reset needed
  always_ff @(posedge mclk) begin
    if (push) mem[wp_q] <= in_data;
  end
  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
endmodule : faic_fifo

module faic_device
  import faic_pkg::*;
#(
  parameter logic [31:0] NATIVE_MAX_LBA = 32'h0000_ffff,
  parameter logic [15:0] CYLINDERS      = 16'h3fff,
  parameter logic [15:0] HEADS          = 16'h0010,
  parameter logic [15:0] BUF_UNITS      = 16'h0100,
  parameter logic [15:0] SERIAL_WORD    = 16'h2020,
  parameter bit          SOFT_SECTORED  = 1'b0
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  faic_if.device                    bus,
  input  wire logic                 reassign_add,
  input  wire faic_pkg::faic_fault_t media_fault,
  input  wire logic                 dev_fault,
  output logic                      sector_wr,
  output logic [31:0]               sector_lba,
  output logic [15:0]               defect_count,
  output logic [15:0]               reassign_count
);
  import faic_pkg::*;

  // A zero native maximum would format only the sector at LBA 0
  if (NATIVE_MAX_LBA == 32'h0) begin : g_bad_max
    $error("faic_device native max LBA must be non-zero");
  end

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_MERGE = 2'b01,
    S_INIT  = 2'b10,
    S_IDENT = 2'b11
  } faic_state_t;

  faic_state_t  st_q, st_d;
  logic [7:0]   status_q, status_d, error_q, error_d, feature_q, feature_d;
  logic         prep_ok_q, prep_ok_d, wr_q, wr_d;
  logic [31:0]  lba_q, lba_d;
  logic [15:0]  defect_q, defect_d, reassign_q, reassign_d, rdata_q, rdata_d;
  logic [8:0]   prod_q, prod_d, pop_q, pop_d;
  logic         f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [15:0]  f_out_data, id_word;
  logic         cmd_wr, data_rd;

  // Identification word contents for words 0 to 47
  always_comb begin
    unique case (prod_q[7:0]) inside
      8'd0:         id_word = SOFT_SECTORED ? ID_W0_SOFT : ID_W0_HARD;
      8'd1:         id_word = CYLINDERS;
      8'd2:         id_word = ID_W2;
      8'd3:         id_word = HEADS;
      8'd6:         id_word = ID_W6;
      [8'd10:8'd19]: id_word = SERIAL_WORD;
      8'd20:        id_word = ID_W20;
      8'd21:        id_word = BUF_UNITS;
      8'd22:        id_word = ID_W22;
      8'd47:        id_word = ID_W47;
      default:      id_word = 16'h0000;
    endcase
  end

  // Producer fills the FIFO while the sector is still incomplete
  assign f_in_valid = (st_q == S_IDENT) && !prod_q[8];
  assign cmd_wr     = bus.wr && (bus.addr == A_STAT_CMD) && !status_q[ST_BUSY];
  assign data_rd    = bus.rd && (bus.addr == A_DATA) && (st_q == S_IDENT);
  assign f_pop      = data_rd && f_out_valid;

  faic_fifo #(
    .W (16),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (id_word),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );

  // Command decode and sequencing
  always_comb begin
    st_d       = st_q;
    status_d   = status_q;
    error_d    = error_q;
    feature_d  = feature_q;
    prep_ok_d  = prep_ok_q;
    lba_d      = lba_q;
    defect_d   = defect_q;
    reassign_d = reassign_q + {15'h0000, reassign_add};
    prod_d     = prod_q + {8'h00, f_in_valid && f_in_ready};
    pop_d      = pop_q + {8'h00, f_pop};
    wr_d       = 1'b0;
    if (bus.wr && bus.addr == A_FEAT_ERR && !status_q[ST_BUSY]) feature_d = bus.wdata[7:0];
    unique case (st_q)
      S_IDLE: begin
        if (cmd_wr) begin
          prep_ok_d = (bus.wdata[7:0] == CMD_ERASE_PREP);
          error_d   = ERROR_RST;
          status_d  = STATUS_RST;
          if (bus.wdata[7:0] == CMD_FORMAT) begin
            if (prep_ok_q && feature_q == FEAT_FORMAT) begin
              st_d              = S_MERGE;
              status_d[ST_BUSY] = 1'b1;
            end else begin
              error_d[ER_ABT]  = 1'b1;
              status_d[ST_ERR] = 1'b1;
            end
          end else if (bus.wdata[7:0] == CMD_IDENTIFY) begin
            st_d              = S_IDENT;
            status_d[ST_BUSY] = 1'b1;
            prod_d            = 9'h000;
            pop_d             = 9'h000;
          end else if (bus.wdata[7:0] != CMD_ERASE_PREP) begin
            error_d[ER_ABT]  = 1'b1;
            status_d[ST_ERR] = 1'b1;
          end
        end
      end
      S_MERGE: begin
        // Fold and clear in one step; a new reassignment is kept
        defect_d   = defect_q + reassign_q;
        reassign_d = {15'h0000, reassign_add};
        lba_d      = 32'h0000_0000;
        st_d       = S_INIT;
      end
      S_INIT: begin
        wr_d  = 1'b1;
        lba_d = lba_q + 32'h0000_0001;
        if (media_fault != FLT_NONE || dev_fault) begin
          error_d[ER_UNC]  = (media_fault == FLT_UNC);
          error_d[ER_IDN]  = (media_fault == FLT_IDN);
          error_d[ER_AMN]  = (media_fault == FLT_AMN);
          status_d         = STATUS_RST;
          status_d[ST_DF]  = dev_fault;
          status_d[ST_ERR] = 1'b1;
          st_d             = S_IDLE;
        end else if (lba_q == NATIVE_MAX_LBA) begin
          status_d = STATUS_RST;
          st_d     = S_IDLE;
        end
      end
      S_IDENT: begin
        if (f_pop && pop_q == 9'(ID_WORDS - 1)) st_d = S_IDLE;
      end
    endcase
    // Data request only during an identification transfer
    status_d[ST_DRQ] = (st_d == S_IDENT) && f_out_valid;
    if (st_q == S_IDENT) status_d[ST_BUSY] = (st_d == S_IDENT) && !f_out_valid;
  end

  // Read answers, registered one cycle after the strobe
  always_comb begin
    rdata_d = rdata_q;
    if (bus.rd) begin
      unique case (bus.addr)
        A_DATA:     rdata_d = f_pop ? f_out_data : 16'h0000;
        A_FEAT_ERR: rdata_d = {8'h00, error_q};
        A_STAT_CMD: rdata_d = {8'h00, status_q};
        default:    rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= S_IDLE;
      status_q   <= STATUS_RST;
      error_q    <= ERROR_RST;
      feature_q  <= 8'h00;
      prep_ok_q  <= 1'b0;
      lba_q      <= 32'h0000_0000;
      defect_q   <= 16'h0000;
      reassign_q <= 16'h0000;
      prod_q     <= 9'h000;
      pop_q      <= 9'h000;
      wr_q       <= 1'b0;
      rdata_q    <= 16'h0000;
    end else begin
      st_q       <= st_d;
      status_q   <= status_d;
      error_q    <= error_d;
      feature_q  <= feature_d;
      prep_ok_q  <= prep_ok_d;
      lba_q      <= lba_d;
      defect_q   <= defect_d;
      reassign_q <= reassign_d;
      prod_q     <= prod_d;
      pop_q      <= pop_d;
      wr_q       <= wr_d;
      rdata_q    <= rdata_d;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sector_lba <= 32'h0000_0000;
    end else if (st_q == S_INIT) begin
      sector_lba <= lba_q;
    end
  end
  assign sector_wr      = wr_q;
  assign defect_count   = defect_q;
  assign reassign_count = reassign_q;
  assign bus.rdata      = rdata_q;
endmodule : faic_device
`default_nettype wire

// >>> faic_pkg.sv
// Shared constants and types for the format and identify command ends
package faic_pkg;
  // Command block register addresses
  localparam logic [2:0] A_DATA     = 3'h0;
  localparam logic [2:0] A_FEAT_ERR = 3'h1;
  localparam logic [2:0] A_STAT_CMD = 3'h7;
  // Command and feature codes
  localparam logic [7:0] CMD_FORMAT     = 8'hf7;
  localparam logic [7:0] CMD_ERASE_PREP = 8'hf3;
  localparam logic [7:0] CMD_IDENTIFY   = 8'hec;
  localparam logic [7:0] FEAT_FORMAT    = 8'h11;
  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DF   = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  // Error bit positions
  localparam int ER_UNC = 6;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int ER_AMN = 0;
  // Values after reset
  localparam logic [7:0] STATUS_RST = 8'h50;
  localparam logic [7:0] ERROR_RST  = 8'h00;
  // Identification sector layout
  localparam int          ID_WORDS   = 256;
  localparam logic [15:0] ID_W0_HARD = 16'h045a;
  localparam logic [15:0] ID_W0_SOFT = 16'h045e;
  localparam logic [15:0] ID_W2      = 16'h37c8;
  localparam logic [15:0] ID_W6      = 16'h003f;
  localparam logic [15:0] ID_W20     = 16'h0003;
  localparam logic [15:0] ID_W22     = 16'h0034;
  localparam logic [15:0] ID_W47     = 16'h8010;
  localparam int          FIFO_DEPTH = 4;
  // Fault kinds reported by the media side during a format
  typedef enum logic [1:0] {
    FLT_NONE = 2'b00,
    FLT_UNC  = 2'b01,
    FLT_IDN  = 2'b10,
    FLT_AMN  = 2'b11
  } faic_fault_t;
endpackage : faic_pkg

// >>> faic_if.sv
// Command block register port between host and device
`timescale 1ns/100ps
`default_nettype none
interface faic_if;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface : faic_if
`default_nettype wire

// >>> faic_host.sv
// Host end: issues erase-prepare plus format, or identify and sector read
`timescale 1ns/100ps
`default_nettype none
module faic_host
  import faic_pkg::*;
#(
  parameter logic [31:0] FMT_TIMEOUT = 32'd50_000_000
) (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  faic_if.host       bus,
  input  wire logic  start_format,
  input  wire logic  start_identify,
  output logic       busy,
  output logic       done,
  output logic       timed_out,
  output logic [7:0] final_status,
  output logic [7:0] final_error,
  output logic [15:0] id_word,
  output logic       id_valid,
  output logic [7:0] id_index
);
  import faic_pkg::*;

  // A zero limit would end every format at once
  if (FMT_TIMEOUT == 32'h0) begin : g_bad_timeout
    $error("faic_host timeout must be non-zero");
  end

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_RD   = 3'b001,
    H_RDW  = 3'b010,
    H_CHK  = 3'b011,
    H_FMT  = 3'b100
  } faic_hstate_t;

  typedef enum logic [2:0] {
    P_PREP = 3'b000,
    P_FMT  = 3'b001,
    P_STAT = 3'b010,
    P_DATA = 3'b011,
    P_ERR  = 3'b100
  } faic_phase_t;

  faic_hstate_t st_q, st_d;
  faic_phase_t  ph_q, ph_d;
  logic [2:0]   addr_q, addr_d;
  logic [15:0]  wdata_q, wdata_d, word_q, word_d;
  logic         wr_q, wr_d, rd_q, rd_d, done_q, done_d, val_q, val_d, to_q, to_d;
  logic [7:0]   stat_q, stat_d, err_q, err_d, idx_q, idx_d;
  logic [31:0]  tmo_q, tmo_d;
  logic         busy_q, busy_d;

  // Sequencer: write, then poll reads through the registered answer
  always_comb begin
    st_d    = st_q;
    ph_d    = ph_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    word_d  = word_q;
    stat_d  = stat_q;
    err_d   = err_q;
    idx_d   = idx_q;
    to_d    = to_q;
    tmo_d   = tmo_q;
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    done_d  = 1'b0;
    val_d   = 1'b0;
    unique case (st_q)
      H_IDLE: begin
        if (start_format || start_identify) begin
          wr_d    = 1'b1;
          addr_d  = A_STAT_CMD;
          wdata_d = {8'h00, start_format ? CMD_ERASE_PREP : CMD_IDENTIFY};
          ph_d    = start_format ? P_PREP : P_STAT;
          idx_d   = 8'h00;
          to_d    = 1'b0;
          tmo_d   = 32'h0000_0000;
          st_d    = H_RD;
        end
      end
      H_RD: begin
        rd_d = 1'b1;
        st_d = H_RDW;
      end
      H_RDW: st_d = H_CHK;
      H_FMT: begin
        wr_d    = 1'b1;
        addr_d  = A_STAT_CMD;
        wdata_d = {8'h00, CMD_FORMAT};
        ph_d    = P_FMT;
        st_d    = H_RD;
      end
      H_CHK: begin
        st_d  = H_RD;
        tmo_d = tmo_q + 32'h0000_0003;
        unique case (ph_q)
          P_PREP: begin
            if (!bus.rdata[ST_BUSY]) begin
              wr_d    = 1'b1;
              addr_d  = A_FEAT_ERR;
              wdata_d = {8'h00, FEAT_FORMAT};
              st_d    = H_FMT;
            end
          end
          P_FMT: begin
            // Time limit stands in for the capacity-based limit
            if (!bus.rdata[ST_BUSY] || tmo_q >= FMT_TIMEOUT) begin
              to_d   = bus.rdata[ST_BUSY];
              stat_d = bus.rdata[7:0];
              ph_d   = P_ERR;
              addr_d = A_FEAT_ERR;
            end
          end
          P_STAT: begin
            if (!bus.rdata[ST_BUSY]) begin
              stat_d = bus.rdata[7:0];
              ph_d   = bus.rdata[ST_DRQ] ? P_DATA : P_ERR;
              addr_d = bus.rdata[ST_DRQ] ? A_DATA : A_FEAT_ERR;
            end
          end
          P_DATA: begin
            word_d = bus.rdata;
            val_d  = 1'b1;
            idx_d  = idx_q + 8'h01;
            ph_d   = P_STAT;
            addr_d = A_STAT_CMD;
          end
          P_ERR: begin
            err_d  = bus.rdata[7:0];
            done_d = 1'b1;
            st_d   = H_IDLE;
          end
          default: st_d = H_IDLE;
        endcase
      end
      default: st_d = H_IDLE;
    endcase
    busy_d = (st_d != H_IDLE); // Busy flag kept in its own flop
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= H_IDLE;
      busy_q  <= 1'b0;
      ph_q    <= P_PREP;
      addr_q  <= A_STAT_CMD;
      wdata_q <= 16'h0000;
      word_q  <= 16'h0000;
      stat_q  <= 8'h00;
      err_q   <= 8'h00;
      idx_q   <= 8'h00;
      to_q    <= 1'b0;
      tmo_q   <= 32'h0000_0000;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      done_q  <= 1'b0;
      val_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      busy_q  <= busy_d;
      ph_q    <= ph_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      word_q  <= word_d;
      stat_q  <= stat_d;
      err_q   <= err_d;
      idx_q   <= idx_d;
      to_q    <= to_d;
      tmo_q   <= tmo_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      done_q  <= done_d;
      val_q   <= val_d;
    end
  end

  // Pin and user outputs from flops
  assign bus.addr     = addr_q;
  assign bus.wdata    = wdata_q;
  assign bus.wr       = wr_q;
  assign bus.rd       = rd_q;
  assign busy         = busy_q;
  assign done         = done_q;
  assign timed_out    = to_q;
  assign final_status = stat_q;
  assign final_error  = err_q;
  assign id_word      = word_q;
  assign id_valid     = val_q;
  assign id_index     = idx_q;
endmodule : faic_host
`default_nettype wire

// >>> faic_monitor.sv
// Bus-side assertions on the port joining host and device ends
`timescale 1ns/100ps
`default_nettype none
module faic_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [2:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata
);
  import faic_pkg::*;
  logic [8:0] idx_q, idx_d;
  logic [7:0] last_q, last_d;
  logic       fmt_q, fmt_d, id_q, id_d;
  wire logic  st_rd  = rd && addr == A_STAT_CMD;
  wire logic  cmd_wr = wr && addr == A_STAT_CMD;
  wire logic  dat_rd = rd && addr == A_DATA;
  // Current command and identify word index
  always_comb begin
    idx_d = dat_rd ? idx_q + 9'h1 : idx_q;
    last_d = cmd_wr ? wdata[7:0] : last_q;
    fmt_d = fmt_q;
    id_d = id_q;
    if (cmd_wr) begin
      idx_d = 9'h0;
      fmt_d = wdata[7:0] == CMD_FORMAT && last_q == CMD_ERASE_PREP;
      id_d = wdata[7:0] == CMD_IDENTIFY;
    end
  end
  // Register the tracking state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 9'h0;
      last_q <= 8'h00;
      fmt_q <= 1'b0;
      id_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      last_q <= last_d;
      fmt_q <= fmt_d;
      id_q <= id_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_prep;
    cmd_wr && wdata[7:0] == CMD_ERASE_PREP;
  endsequence
  sequence s_fmt;
    cmd_wr && wdata[7:0] == CMD_FORMAT && last_q == CMD_ERASE_PREP;
  endsequence
  property p_word(int n, logic [15:0] v);
    id_q && dat_rd && idx_q == n |=> rdata == v;
  endproperty
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  prep_status_a: assert property (s_prep ##1 st_rd |=> rdata[7:0] == 8'h50)
    else $error("erase prepare did not end clean");
  fmt_busy_a: assert property (s_fmt ##1 st_rd |=> rdata[ST_BUSY])
    else $error("format not busy");
  fmt_nodrq_a: assert property (fmt_q && st_rd |=> !rdata[ST_DRQ])
    else $error("data request during format");
  id_error_a: assert property (
    id_q && rd && addr == A_FEAT_ERR |=> rdata[7:0] ==? 8'b0000_0?00)
    else $error("identify error other than abort");
  id_count_a: assert property (id_q && dat_rd |-> idx_q < 9'd256)
    else $error("more than one sector read");
  word0_value_a: assert property (
    id_q && dat_rd && idx_q == 0 |=> rdata inside {16'h045a, 16'h045e})
    else $error("word 0 wrong");
  word2_value_a: assert property (p_word(2, 16'h37c8))
    else $error("word 2 wrong");
  word6_value_a: assert property (p_word(6, 16'h003f))
    else $error("word 6 wrong");
  word20_value_a: assert property (p_word(20, 16'h0003))
    else $error("word 20 wrong");
  word22_value_a: assert property (p_word(22, 16'h0034))
    else $error("word 22 wrong");
  word47_value_a: assert property (p_word(47, 16'h8010))
    else $error("word 47 wrong");
endmodule : faic_monitor
`default_nettype wire

// >>> format_and_identify_cmds_bench.sv
// Self-checking bench for the format and identify command ends
`timescale 1ns/100ps
`default_nettype none
module format_and_identify_cmds_bench;
  import faic_pkg::*;
  localparam logic [31:0] MAXLBA = 32'd15;
  logic        mclk, rst_n, start_format, start_identify, reassign_add, dev_fault;
  logic        busy, done, timed_out, id_valid, sector_wr;
  logic [7:0]  final_status, final_error, id_index, c;
  logic [15:0] id_word, defect_count, reassign_count, q;
  logic [15:0] idw [256];
  logic [31:0] sector_lba, seed, nsec, cycles, k;
  faic_fault_t media_fault;
  int          mismatches, compares, nid, i, n, m, df;
  faic_if link ();
  faic_if probe ();
  faic_host #(.FMT_TIMEOUT(32'd500)) u_faic_host (.mclk(mclk), .rst_n(rst_n),
    .bus(link.host), .start_format(start_format), .start_identify(start_identify),
    .busy(busy), .done(done), .timed_out(timed_out), .final_status(final_status),
    .final_error(final_error), .id_word(id_word), .id_valid(id_valid), .id_index(id_index));
  faic_device #(.NATIVE_MAX_LBA(MAXLBA)) u_faic_device (.mclk(mclk), .rst_n(rst_n),
    .bus(link.device), .reassign_add(reassign_add), .media_fault(media_fault),
    .dev_fault(dev_fault), .sector_wr(sector_wr), .sector_lba(sector_lba),
    .defect_count(defect_count), .reassign_count(reassign_count));
  faic_device #(.NATIVE_MAX_LBA(MAXLBA)) u_faic_device_2 (.mclk(mclk), .rst_n(rst_n),
    .bus(probe.device), .reassign_add(reassign_add), .media_fault(media_fault),
    .dev_fault(dev_fault), .sector_wr(), .sector_lba(), .defect_count(),
    .reassign_count());
  faic_monitor u_faic_monitor (.mclk(mclk), .rst_n(rst_n), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] exp_word(input int w);
    case (w)
      0: return 16'h045a;
      1: return 16'h3fff;
      2: return 16'h37c8;
      3: return 16'h0010;
      6: return 16'h003f;
      20: return 16'h0003;
      21: return 16'h0100;
      22: return 16'h0034;
      47: return 16'h8010;
      default: return (w >= 10 && w <= 19) ? 16'h2020 : 16'h0000;
    endcase
  endfunction : exp_word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Host command run, waiting for done under a bound
  task automatic run(input bit fmt);
    @(negedge mclk);
    if (fmt)
      nsec = '0;
    start_format = fmt;
    start_identify = !fmt;
    @(negedge mclk);
    start_format = 1'b0;
    start_identify = 1'b0;
    chk(busy, 1, "host busy");
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chk(done, 1, "done seen");
    chk(busy, 0, "host idle");
  endtask : run
  // Register write and read on the second device
  task automatic pw(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    probe.addr = a;
    probe.wdata = {8'h00, d};
    probe.wr = 1'b1;
    @(negedge mclk);
    probe.wr = 1'b0;
  endtask : pw
  task automatic pr(input logic [2:0] a, output logic [15:0] r);
    @(negedge mclk);
    probe.addr = a;
    probe.rd = 1'b1;
    @(negedge mclk);
    probe.rd = 1'b0;
    r = probe.rdata;
  endtask : pr
  task automatic expect_regs(input logic [7:0] st, input logic [7:0] er);
    pr(A_FEAT_ERR, q);
    chk(q[7:0], er, "error register");
    pr(A_STAT_CMD, q);
    chk(q[7:0], st, "status register");
  endtask : expect_regs
  // Clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 32'd1;
    if (cycles == 32'd20000) begin
      mismatches++;
      final_report();
    end
  end
  // Sector order and identify word capture
  always @(negedge mclk) begin
    if (sector_wr === 1'b1) begin
      chk(sector_lba, nsec, "sector address");
      nsec <= nsec + 32'd1;
    end
    if (id_valid === 1'b1) begin
      idw[8'(id_index - 8'h01)] <= id_word;
      nid <= nid + 1;
    end
  end
  // Main sequence
  initial begin
    {rst_n, start_format, start_identify, reassign_add, dev_fault} = '0;
    media_fault = FLT_NONE;
    {probe.wr, probe.rd, probe.wdata} = '0;
    probe.addr = A_STAT_CMD;
    {mismatches, compares, nid} = '0;
    {cycles, nsec} = '0;
    seed = 32'h735f1189;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    expect_regs(STATUS_RST, ERROR_RST);
    k = rnd() % 5 + 1;
    repeat (k) begin
      @(negedge mclk);
      reassign_add = 1'b1;
      @(negedge mclk);
      reassign_add = 1'b0;
    end
    @(negedge mclk);
    chk(reassign_count, k, "reassign count");
    run(1'b1);
    chk(nsec, MAXLBA + 1, "sector total");
    chk(defect_count, k, "defects merged");
    chk(reassign_count, 0, "reassign cleared");
    chk({final_status, final_error}, 16'h5000, "format result");
    chk(timed_out, 0, "format timeout");
    for (i = 1; i < 4; i++) begin
      df = rnd() & 1;
      media_fault = faic_fault_t'(i);
      dev_fault = df[0];
      run(1'b1);
      media_fault = FLT_NONE;
      dev_fault = 1'b0;
      chk(final_error, i == 1 ? 8'h40 : i == 2 ? 8'h10 : 8'h01, "fault error");
      chk(final_status, df ? 8'h71 : 8'h51, "fault status");
    end
    run(1'b0);
    chk(nid, 256, "word total");
    chk({final_status, final_error, id_index}, 24'h500000, "identify end");
    for (i = 0; i < 256; i++)
      chk(idw[i], exp_word(i), "id word");
    pw(A_FEAT_ERR, FEAT_FORMAT);
    pw(A_STAT_CMD, CMD_FORMAT);
    expect_regs(8'h51, 8'h04);
    pw(A_STAT_CMD, CMD_ERASE_PREP);
    pw(A_FEAT_ERR, 8'h10);
    pw(A_STAT_CMD, CMD_FORMAT);
    expect_regs(8'h51, 8'h04);
    do c = 8'(rnd()); while (c inside {CMD_FORMAT, CMD_ERASE_PREP, CMD_IDENTIFY});
    pw(A_STAT_CMD, CMD_ERASE_PREP);
    pw(A_STAT_CMD, c);
    expect_regs(8'h51, 8'h04);
    pw(A_FEAT_ERR, FEAT_FORMAT);
    pw(A_STAT_CMD, CMD_FORMAT);
    expect_regs(8'h51, 8'h04);
    pr(A_DATA, q);
    chk(q, 0, "idle data read");
    pw(A_STAT_CMD, CMD_ERASE_PREP);
    pw(A_STAT_CMD, CMD_FORMAT);
    pr(A_STAT_CMD, q);
    chk(q[ST_BUSY], 1, "format busy");
    for (m = 0; m < 40 && q[ST_BUSY]; m++) begin
      chk(q[ST_DRQ], 0, "no data request");
      pr(A_STAT_CMD, q);
    end
    expect_regs(8'h50, 8'h00);
    // Identify on the probe end, drained at a random pace through its FIFO
    pw(A_STAT_CMD, CMD_IDENTIFY);
    repeat (FIFO_DEPTH + 2) @(negedge mclk);
    pr(A_STAT_CMD, q);
    chk(q[7:0], 8'h58, "fifo fill");
    for (m = 0; m < 256; m++) begin
      repeat (rnd() % 3) @(negedge mclk);
      pr(A_DATA, q);
      chk(q, exp_word(m), "fifo order");
    end
    pr(A_STAT_CMD, q);
    chk(q[7:0], 8'h50, "fifo empty");
    final_report();
  end
endmodule : format_and_identify_cmds_bench
`default_nettype wire
